// *** hdl/tbl_tst_pkg.sv ***
package tbl_tst_pkg;
	// ----------------------------------------------------------------
	// Opcode patterns
	// ----------------------------------------------------------------
	localparam logic [13:0] TW_OP_HI       = 14'h0003; // Word[15:2]
	localparam logic [6:0]  TSTZ_OP_HI     = 7'h33;    // Word[15:9]
	localparam logic [7:0]  ACCESS_HI_BASE = 8'h60;    // First access SFR offset
	localparam logic [7:0]  INDEX_LIMIT    = 8'h5f;    // Indexed window top
	localparam logic [3:0]  ACCESS_SFR_BNK = 4'hf;     // Bank of upper access range (0x60 and up)
	localparam int          PTR_W          = 21;
	localparam int          HOLD_N         = 8;
	localparam int          HOLD_SEL_W     = 3;

	// ----------------------------------------------------------------
	// Pointer modes
	// ----------------------------------------------------------------
	localparam logic [1:0] PM_NONE = 2'h0;
	localparam logic [1:0] PM_POST_INC = 2'h1;
	localparam logic [1:0] PM_POST_DEC = 2'h2;
	localparam logic [1:0] PM_PRE_INC = 2'h3;

	localparam logic [20:0] PTR_RESET = 21'h000000;
	localparam logic [20:0] PTR_ONE   = 21'h000001;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_TW2   = 4'h2,
		ST_SKIP1 = 4'h4,
		ST_SKIP2 = 4'h8
	} state_type;
endpackage

// *** hdl/table_write_and_zero_skip.sv ***
`timescale 1ns/1ns
// How it works
// - A table write takes two cycles: decode, then latch copied into a holding register.
// - A zero file value makes the test discard the prefetched word and run a nop: two cycles.
// - If that skipped word is the first of a two-word instruction, the test takes three cycles.
// - The zero test is one word and finishes in two cycles on a nonzero value.
// - Bank bit zero picks the access bank; one picks the bank from the bank select register.
// - With the extension on and bank bit zero, addresses up to 95 are indexed off a base.
// - The three low pointer bits choose one of eight holding registers.
// - The low two opcode bits give none, post-increment, post-decrement or pre-increment.
module table_write_and_zero_skip
	import tbl_tst_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// Instruction stream, one word per cycle
	input  wire logic              instr_valid,
	input  wire logic [15:0]       instr_word,
	input  wire logic              next_is_two_word,
	// Configuration and data path
	input  wire logic              ext_set_en,
	input  wire logic [3:0]        bank_select_reg,
	input  wire logic [11:0]       index_base,
	input  wire logic [7:0]        table_latch,
	input  wire logic [7:0]        file_rdata,
	// File address and results
	output logic      [11:0]       file_addr,
	output logic                   busy,
	output logic                   discard,
	output logic                   op_done,
	output logic      [PTR_W-1:0]  table_pointer,
	output logic      [7:0]        hold_regs [HOLD_N]
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		state_type              st;
		logic                   skip_two;
		logic [HOLD_SEL_W-1:0]  sel;
		logic [PTR_W-1:0]       ptr;
		logic [11:0]            addr;
		logic                   busy;
		logic                   discard;
		logic                   done;
		logic [HOLD_N-1:0][7:0] hold;
	} regs_type;

	regs_type s_r, s_nxt;

	wire logic is_tw  = instr_word[15:2] == TW_OP_HI;
	wire logic is_tst = instr_word[15:9] == TSTZ_OP_HI;
	wire logic [7:0] f_fld = instr_word[7:0];
	wire logic a_bit = instr_word[8];

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_nxt         = s_r;
		s_nxt.done    = 1'b0;
		s_nxt.discard = 1'b0;
		case (s_r.st)
			ST_IDLE: begin
				s_nxt.busy = 1'b0;
				if (instr_valid && is_tw) begin
					s_nxt.st   = ST_TW2;
					s_nxt.busy = 1'b1;
					// Pre-increment moves the pointer before selecting
					case (instr_word[1:0])
						PM_POST_INC: begin
							s_nxt.sel = s_r.ptr[HOLD_SEL_W-1:0];
							s_nxt.ptr = s_r.ptr + PTR_ONE;
						end
						PM_POST_DEC: begin
							s_nxt.sel = s_r.ptr[HOLD_SEL_W-1:0];
							s_nxt.ptr = s_r.ptr - PTR_ONE;
						end
						PM_PRE_INC: begin
							s_nxt.ptr = s_r.ptr + PTR_ONE;
							s_nxt.sel = s_nxt.ptr[HOLD_SEL_W-1:0];
						end
						default: s_nxt.sel = s_r.ptr[HOLD_SEL_W-1:0];
					endcase
				end else if (instr_valid && is_tst) begin
					// Address formed now, value tested next cycle
					if (!a_bit && ext_set_en && f_fld <= INDEX_LIMIT)
						s_nxt.addr = index_base + {4'h0, f_fld};
					else if (!a_bit)
						s_nxt.addr = (f_fld < ACCESS_HI_BASE) ? {4'h0, f_fld}
							: {ACCESS_SFR_BNK, f_fld};
					else
						s_nxt.addr = {bank_select_reg, f_fld};
					s_nxt.skip_two = next_is_two_word;
					s_nxt.st       = ST_SKIP1;
					s_nxt.busy     = 1'b1;
				end
			end
			ST_TW2: begin
				// Only the holding register changes; no flags, no flash
				s_nxt.hold[s_r.sel] = table_latch;
				s_nxt.st            = ST_IDLE;
				s_nxt.busy          = 1'b0;
				s_nxt.done          = 1'b1;
			end
			ST_SKIP1: begin
				if (file_rdata == 8'h00) begin
					s_nxt.discard = 1'b1;
					s_nxt.st      = s_r.skip_two ? ST_SKIP2 : ST_IDLE;
					s_nxt.busy    = s_r.skip_two;
					s_nxt.done    = !s_r.skip_two;
				end else begin
					s_nxt.st   = ST_IDLE;
					s_nxt.busy = 1'b0;
					s_nxt.done = 1'b1;
				end
			end
			ST_SKIP2: begin
				s_nxt.discard = 1'b1;
				s_nxt.st      = ST_IDLE;
				s_nxt.busy    = 1'b0;
				s_nxt.done    = 1'b1;
			end
			default: s_nxt.st = ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------------
	// Register
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r     <= '0;
			s_r.st  <= ST_IDLE;
			s_r.ptr <= PTR_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flops
	assign file_addr     = s_r.addr;
	assign busy          = s_r.busy;
	assign discard       = s_r.discard;
	assign op_done       = s_r.done;
	assign table_pointer = s_r.ptr;
	generate
		for (genvar i = 0; i < HOLD_N; i++) begin : g_hold
			assign hold_regs[i] = s_r.hold[i];
		end
	endgenerate

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence s_tw_start;
		s_r.st == ST_IDLE && instr_valid && is_tw;
	endsequence

	property p_tw_two;
		@(posedge clk) disable iff (!rst_b)
		s_tw_start |=> s_r.st == ST_TW2 ##1 s_r.done && s_r.st == ST_IDLE;
	endproperty
	a_tw_two: assert property (p_tw_two) else $error("table write not two cycles");

	property p_tw_hold;
		@(posedge clk) disable iff (!rst_b)
		s_r.st == ST_TW2 |=> s_r.hold[$past(s_r.sel)] == $past(table_latch);
	endproperty
	a_tw_hold: assert property (p_tw_hold) else $error("latch not written");

	property p_post_inc;
		@(posedge clk) disable iff (!rst_b)
		s_tw_start and instr_word[1:0] == PM_POST_INC
		|=> s_r.ptr == $past(s_r.ptr) + PTR_ONE && s_r.sel == $past(s_r.ptr[2:0]);
	endproperty
	a_post_inc: assert property (p_post_inc) else $error("post increment wrong");

	property p_post_dec;
		@(posedge clk) disable iff (!rst_b)
		s_tw_start and instr_word[1:0] == PM_POST_DEC |=> s_r.ptr == $past(s_r.ptr) - PTR_ONE;
	endproperty
	a_post_dec: assert property (p_post_dec) else $error("post decrement wrong");

	property p_skip_zero;
		@(posedge clk) disable iff (!rst_b)
		s_r.st == ST_SKIP1 && file_rdata == 8'h00 |=> discard;
	endproperty
	a_skip_zero: assert property (p_skip_zero) else $error("zero not skipped");

	property p_skip_three;
		@(posedge clk) disable iff (!rst_b)
		s_r.st == ST_SKIP1 && file_rdata == 8'h00 && s_r.skip_two
		|=> discard [*2] ##0 op_done;
	endproperty
	a_skip_three: assert property (p_skip_three) else $error("two word skip wrong");

	property p_nonzero;
		@(posedge clk) disable iff (!rst_b)
		s_r.st == ST_SKIP1 && file_rdata != 8'h00 |=> op_done && !discard;
	endproperty
	a_nonzero: assert property (p_nonzero) else $error("nonzero test wrong");

	property p_bank;
		@(posedge clk) disable iff (!rst_b)
		s_r.st == ST_IDLE && instr_valid && is_tst && a_bit
		|=> file_addr == {$past(bank_select_reg), $past(f_fld)};
	endproperty
	a_bank: assert property (p_bank) else $error("bank address wrong");

	property p_indexed;
		@(posedge clk) disable iff (!rst_b)
		s_r.st == ST_IDLE && instr_valid && is_tst && !a_bit && ext_set_en
			&& f_fld <= INDEX_LIMIT
		|=> file_addr == $past(index_base) + {4'h0, $past(f_fld)};
	endproperty
	a_indexed: assert property (p_indexed) else $error("indexed address wrong");
endmodule

// *** bench/tb_table_write_and_zero_skip.sv ***
`timescale 1ns/1ns
module tb_table_write_and_zero_skip;
	import tbl_tst_pkg::*;
	typedef struct {
		logic [31:0] t_done;
		logic [31:0] disc;
		logic [20:0] ptr;
		logic        chk_addr;
		logic [11:0] addr;
		logic [7:0]  hold [HOLD_N];
	} note_type;
	// ----------------------------------------
	// Design signals and bench state
	// ----------------------------------------
	logic             clk, rst_b, instr_valid, next_is_two_word, ext_set_en;
	logic [15:0]      instr_word;
	logic [3:0]       bank_select_reg;
	logic [11:0]      index_base, file_addr;
	logic [7:0]       table_latch, file_rdata;
	logic             busy, discard, op_done;
	logic [PTR_W-1:0] table_pointer;
	logic [7:0]       hold_regs [HOLD_N];
	logic [7:0]       m_hold [HOLD_N] = '{default: 8'h00};
	logic [20:0]      m_ptr = PTR_RESET;
	logic [31:0]      cyc = 0, dcnt = 0;
	logic [1:0]       modes [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
	note_type         notes [$];
	note_type         n;
	int               mismatches = 0, num_checks = 0, r;

	table_write_and_zero_skip table_write_and_zero_skip_i (.clk(clk), .rst_b(rst_b),
		.instr_valid(instr_valid), .instr_word(instr_word),
		.next_is_two_word(next_is_two_word), .ext_set_en(ext_set_en),
		.bank_select_reg(bank_select_reg), .index_base(index_base),
		.table_latch(table_latch), .file_rdata(file_rdata), .file_addr(file_addr),
		.busy(busy), .discard(discard), .op_done(op_done),
		.table_pointer(table_pointer), .hold_regs(hold_regs));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Queue the expected outcome, then present the word for one take edge
	task automatic issue(input logic [15:0] w, input logic two, input logic [7:0] d);
		note_type    e;
		logic [20:0] sel;
		int          k;
		k = 0;
		while (busy !== 1'b0 && k < 20) begin
			@(negedge clk);
			k++;
		end
		if (busy !== 1'b0) begin
			mismatches++;
			wrap_up();
		end
		e.chk_addr = (w[15:2] != TW_OP_HI);
		e.disc = 0;
		e.t_done = cyc + 2;
		if (!e.chk_addr) begin
			sel = (w[1:0] == PM_PRE_INC) ? m_ptr + PTR_ONE : m_ptr;
			if (w[1:0] == PM_POST_DEC)
				m_ptr = m_ptr - PTR_ONE;
			else if (w[1:0] != PM_NONE)
				m_ptr = m_ptr + PTR_ONE;
			m_hold[sel[2:0]] = d;
		end else begin
			if (w[8])
				e.addr = {bank_select_reg, w[7:0]};
			else if (ext_set_en && w[7:0] <= INDEX_LIMIT)
				e.addr = index_base + {4'h0, w[7:0]};
			else
				e.addr = (w[7:0] < ACCESS_HI_BASE) ? {4'h0, w[7:0]} : {ACCESS_SFR_BNK, w[7:0]};
			if (d == 8'h00) begin
				e.disc = two ? 2 : 1;
				e.t_done = cyc + (two ? 3 : 2);
			end
		end
		e.ptr = m_ptr;
		e.hold = m_hold;
		notes.push_back(e);
		{instr_word, instr_valid, next_is_two_word, table_latch, file_rdata} = {w, 1'b1, two, d, d};
		@(negedge clk);
		chk("busy", 1, busy);
		instr_word = 16'h000d; // Held while busy: must be ignored
		@(negedge clk);
		instr_valid = 1'b0;
		// Let an edge pass so valid never falls and rises in one step
		@(negedge clk);
	endtask

	// ----------------------------------------
	// Clock and result watcher
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) cyc <= cyc + 1;

	// Sampled at the falling edge, after the design has settled
	always @(negedge clk) if (rst_b) begin
		if (discard === 1'b1) dcnt = dcnt + 1;
		if (op_done === 1'b1) begin
			if (notes.size() == 0) begin
				chk("op_done", 0, 1);
			end else begin
				n = notes.pop_front();
				chk("done_cycle", n.t_done, cyc);
				chk("discards", n.disc, dcnt);
				chk("pointer", n.ptr, table_pointer);
				chk("busy_end", 0, busy);
				if (n.chk_addr) chk("file_addr", n.addr, file_addr);
				for (int i = 0; i < HOLD_N; i++) chk("hold", n.hold[i], hold_regs[i]);
			end
			dcnt = 0;
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_b, instr_valid, instr_word, next_is_two_word, ext_set_en} = '0;
		{bank_select_reg, index_base, table_latch, file_rdata} = '0;
		void'($urandom(32'h4387));
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		chk("reset_ptr", 0, table_pointer);
		// Post-decrement first, so the pointer wraps below zero
		for (int m = 0; m < 4; m++) issue({TW_OP_HI, modes[m]}, 1'b0, 8'($urandom));
		bank_select_reg = 4'h5;
		issue({TSTZ_OP_HI, 9'h123}, 1'b0, 8'h00);
		issue({TSTZ_OP_HI, 9'h123}, 1'b1, 8'h00);
		issue({TSTZ_OP_HI, 9'h123}, 1'b1, 8'h01);
		issue({TSTZ_OP_HI, 9'h05f}, 1'b0, 8'h80);
		issue({TSTZ_OP_HI, 9'h060}, 1'b0, 8'h00);
		{ext_set_en, index_base} = {1'b1, 12'h3f0};
		issue({TSTZ_OP_HI, 9'h05f}, 1'b1, 8'h00);
		issue({TSTZ_OP_HI, 9'h060}, 1'b0, 8'h07);
		issue({TSTZ_OP_HI, 9'h000}, 1'b0, 8'h01);
		// Mid-run reset must clear pointer and holding registers
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		m_ptr = PTR_RESET;
		m_hold = '{default: 8'h00};
		chk("mid_reset_ptr", 0, table_pointer);
		chk("mid_reset_hold", 0, hold_regs[0]);
		// Random mix of both operations and addressing setups
		for (int i = 0; i < 60; i++) begin
			{ext_set_en, bank_select_reg, index_base} = 17'($urandom);
			r = $urandom % 3;
			if (r == 0)
				issue({TW_OP_HI, 2'($urandom)}, 1'b0, 8'($urandom));
			else
				issue({TSTZ_OP_HI, 9'($urandom)}, 1'($urandom), (r == 1) ? 8'h00 : 8'($urandom));
		end
		repeat (10) @(negedge clk);
		chk("pending", 0, notes.size());
		wrap_up();
	end
endmodule
